// ---- shared/gbcd_pkg.sv ----
package gbcd_pkg;

    // Multiline interface command codes, seven bits, sent with attention true.
    localparam logic [6:0] CMD_GTL = 7'h01;
    localparam logic [6:0] CMD_SDC = 7'h04;
    localparam logic [6:0] CMD_GET = 7'h08;
    localparam logic [6:0] CMD_LLO = 7'h11;
    localparam logic [6:0] CMD_DCL = 7'h14;
    localparam logic [6:0] CMD_SPE = 7'h18;
    localparam logic [6:0] CMD_SPD = 7'h19;
    localparam logic [6:0] CMD_UNL = 7'h3F;
    localparam logic [6:0] CMD_UNT = 7'h5F;

    // Address groups are told apart by bits 6 and 5 of the byte.
    localparam logic [6:0] GRP_MASK = 7'h60;
    localparam logic [6:0] GRP_LAG  = 7'h20;
    localparam logic [6:0] GRP_TAG  = 7'h40;
    localparam logic [6:0] GRP_SCG  = 7'h60;

    // Highest primary address the device accepts.
    localparam logic [4:0] ADDR_MAX = 5'h1E;

    // Position of the service request bit in the returned status byte.
    localparam int unsigned STB_RQS_POS = 6;

    // Reset values of control state and of open-drain enables.
    localparam logic RST_CLR = 1'b0;
    localparam logic RST_REL = 1'b1;

endpackage : gbcd_pkg

// ---- verilog/gbcd_acceptor.sv ----
`timescale 1ns/1ns
`default_nettype none

module gbcd_acceptor (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_active,
    input  wire logic       i_hold,
    input  wire logic       i_dav_n,
    input  wire logic       i_atn_n,
    input  wire logic       i_eoi_n,
    input  wire logic [7:0] i_dio_n,
    output var  logic       o_nrfd_oe_n,
    output var  logic       o_ndac_oe_n,
    output var  logic [7:0] o_byte,
    output var  logic       o_eoi,
    output var  logic       o_atn,
    output var  logic       o_strobe
);

    typedef enum logic [1:0] {AC_IDLE, AC_READY, AC_ACCEPT, AC_WAIT} gbcd_acc_t;

    gbcd_acc_t state_q;

    always_ff @(posedge i_clk) begin
        o_strobe <= gbcd_pkg::RST_CLR;
        if (!i_rst_n) begin
            state_q     <= AC_IDLE;
            o_nrfd_oe_n <= gbcd_pkg::RST_REL;
            o_ndac_oe_n <= gbcd_pkg::RST_REL;
            o_byte      <= 8'h00;
            o_eoi       <= gbcd_pkg::RST_CLR;
            o_atn       <= gbcd_pkg::RST_CLR;
        end else if (!i_active) begin
            // A device that takes no part leaves both acceptor lines released.
            state_q     <= AC_IDLE;
            o_nrfd_oe_n <= gbcd_pkg::RST_REL;
            o_ndac_oe_n <= gbcd_pkg::RST_REL;
        end else begin
            case (state_q)
                AC_IDLE: begin
                    state_q     <= AC_READY;
                    o_ndac_oe_n <= 1'b0;
                    o_nrfd_oe_n <= 1'b0;
                end
                AC_READY: begin
                    o_nrfd_oe_n <= !i_hold;
                    if (!i_dav_n && o_nrfd_oe_n) begin
                        o_byte      <= ~i_dio_n;
                        o_eoi       <= !i_eoi_n;
                        o_atn       <= !i_atn_n;
                        o_strobe    <= 1'b1;
                        o_nrfd_oe_n <= 1'b0;
                        state_q     <= AC_ACCEPT;
                    end
                end
                AC_ACCEPT: begin
                    o_ndac_oe_n <= 1'b1;
                    state_q     <= AC_WAIT;
                end
                AC_WAIT: begin
                    if (i_dav_n) begin
                        o_ndac_oe_n <= 1'b0;
                        state_q     <= AC_READY;
                    end
                end
                default: state_q <= AC_IDLE;
            endcase
        end
    end

endmodule : gbcd_acceptor

`default_nettype wire

// ---- verilog/gbcd_source.sv ----
`timescale 1ns/1ns
`default_nettype none

module gbcd_source (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_enable,
    input  wire logic       i_valid,
    input  wire logic [7:0] i_data,
    input  wire logic       i_end,
    input  wire logic       i_nrfd_n,
    input  wire logic       i_ndac_n,
    output var  logic [7:0] o_dio_n,
    output var  logic       o_dio_oe_n,
    output var  logic       o_dav_oe_n,
    output var  logic       o_eoi_oe_n,
    output var  logic       o_done
);

    typedef enum logic [1:0] {SR_IDLE, SR_SETTLE, SR_ASSERT} gbcd_src_t;

    gbcd_src_t state_q;

    always_ff @(posedge i_clk) begin
        o_done <= gbcd_pkg::RST_CLR;
        if (!i_rst_n || !i_enable) begin
            // Attention taking over aborts the byte and frees the bus at once.
            state_q    <= SR_IDLE;
            o_dio_n    <= 8'hFF;
            o_dio_oe_n <= gbcd_pkg::RST_REL;
            o_dav_oe_n <= gbcd_pkg::RST_REL;
            o_eoi_oe_n <= gbcd_pkg::RST_REL;
        end else begin
            case (state_q)
                SR_IDLE: begin
                    if (i_valid) begin
                        o_dio_n    <= ~i_data;
                        o_dio_oe_n <= 1'b0;
                        o_eoi_oe_n <= !i_end;
                        state_q    <= SR_SETTLE;
                    end
                end
                SR_SETTLE: begin
                    if (i_nrfd_n && !i_ndac_n) begin
                        o_dav_oe_n <= 1'b0;
                        state_q    <= SR_ASSERT;
                    end
                end
                SR_ASSERT: begin
                    if (i_ndac_n) begin
                        o_dav_oe_n <= 1'b1;
                        o_dio_oe_n <= 1'b1;
                        o_eoi_oe_n <= 1'b1;
                        o_dio_n    <= 8'hFF;
                        o_done     <= 1'b1;
                        state_q    <= SR_IDLE;
                    end
                end
                default: state_q <= SR_IDLE;
            endcase
        end
    end

endmodule : gbcd_source

`default_nettype wire

// ---- verilog/gbcd_top.sv ----
`timescale 1ns/1ns
`default_nettype none

// Contract
// - Bus lines true when low
// - Attention bytes are interface commands
// - Non-attention bytes go to data path
// - Controller owns attention, clear, remote
// - Remote enable leaves local, optional lockout
// - End marker flags last byte
// - Interface clear idles talker and listener
// - Hold service request until serviced
// - Universal commands need no addressing
// - Local lockout disables local key
// - Device clear restores defaults
// - Poll enable enters, disable leaves poll
// - Addressed commands need listen address first
// - Selective clear only when listening
// - Go-to-local leaves remote, maybe unlocks
// - Group trigger starts triggered action
// - Listen address is address OR 20
// - Talk address is address OR 40
// - Secondary group bytes are ignored
// - Unlisten enters listener idle
// - Untalk enters talker idle
// - Decode the fixed command codes
// - Primary address limited to 0..30
// - Interlocked three-wire byte handshake
module gbcd_top (
    input  wire logic       I_CLK_SYS,
    input  wire logic       I_NRST,
    input  wire logic [4:0] I_PRI_ADDR,
    input  wire logic       I_REN_LOCKS_PANEL,
    input  wire logic       I_GTL_UNLOCKS,
    input  wire logic       I_ATN_N,
    input  wire logic       I_IFC_N,
    input  wire logic       I_REN_N,
    input  wire logic       I_EOI_N,
    input  wire logic       I_DAV_N,
    input  wire logic       I_NRFD_N,
    input  wire logic       I_NDAC_N,
    input  wire logic [7:0] I_DIO_N,
    input  wire logic       I_LOCAL_KEY,
    input  wire logic       I_SVC_REQ,
    input  wire logic [7:0] I_STATUS,
    input  wire logic       I_TX_VALID,
    input  wire logic [7:0] I_TX_DATA,
    input  wire logic       I_TX_END,
    input  wire logic       I_RX_READY,
    output var  logic [7:0] O_DIO_N,
    output var  logic       O_DIO_OE_N,
    output var  logic       O_DAV_N,
    output var  logic       O_DAV_OE_N,
    output var  logic       O_NRFD_N,
    output var  logic       O_NRFD_OE_N,
    output var  logic       O_NDAC_N,
    output var  logic       O_NDAC_OE_N,
    output var  logic       O_EOI_N,
    output var  logic       O_EOI_OE_N,
    output var  logic       O_SRQ_N,
    output var  logic       O_SRQ_OE_N,
    output var  logic [7:0] O_RX_DATA,
    output var  logic       O_RX_VALID,
    output var  logic       O_RX_END,
    output var  logic       O_TX_ACK,
    output var  logic       O_LISTEN,
    output var  logic       O_TALK,
    output var  logic       O_SPOLL,
    output var  logic       O_REMOTE,
    output var  logic       O_LOCKOUT,
    output var  logic       O_PANEL_LOCK,
    output var  logic       O_DEV_CLEAR,
    output var  logic       O_TRIGGER,
    output var  logic       O_SRQ_PEND
);

    logic [4:0] addr_q;
    logic       listen_q;
    logic       talk_q;
    logic       spoll_q;
    logic       remote_q;
    logic       lockout_q;
    logic       srq_q;
    logic       ren_prev_q;
    logic       pin_low_q;

    logic [7:0] acc_byte;
    logic       acc_eoi;
    logic       acc_atn;
    logic       acc_strobe;
    logic       acc_active;
    logic       acc_hold;

    logic       src_enable;
    logic       src_valid;
    logic [7:0] src_data;
    logic       src_end;
    logic       src_done;

    logic       atn;
    logic       ifc;
    logic       ren;
    logic [6:0] cmd;
    logic       is_cmd;
    logic [6:0] my_listen;
    logic [6:0] my_talk;
    logic       hit_mla;
    logic       hit_mta;
    logic       hit_ota;
    logic       hit_unl;
    logic       hit_unt;
    logic       hit_llo;
    logic       hit_dcl;
    logic       hit_spe;
    logic       hit_spd;
    logic       hit_gtl;
    logic       hit_sdc;
    logic       hit_get;
    logic       stb_sent;

    assign atn = !I_ATN_N;
    assign ifc = !I_IFC_N;
    assign ren = !I_REN_N;

    assign is_cmd = acc_strobe && acc_atn;
    // The eighth data line carries no meaning in an interface command.
    assign cmd    = acc_byte[6:0];

    assign my_listen = gbcd_pkg::GRP_LAG | {2'b00, addr_q};
    assign my_talk   = gbcd_pkg::GRP_TAG | {2'b00, addr_q};

    assign hit_mla = is_cmd && (cmd == my_listen);
    assign hit_mta = is_cmd && (cmd == my_talk);
    assign hit_ota = is_cmd && ((cmd & gbcd_pkg::GRP_MASK) == gbcd_pkg::GRP_TAG)
                     && (cmd != my_talk) && (cmd != gbcd_pkg::CMD_UNT);

    assign hit_unl = is_cmd && (cmd == gbcd_pkg::CMD_UNL);
    assign hit_unt = is_cmd && (cmd == gbcd_pkg::CMD_UNT);
    assign hit_llo = is_cmd && (cmd == gbcd_pkg::CMD_LLO);
    assign hit_dcl = is_cmd && (cmd == gbcd_pkg::CMD_DCL);
    assign hit_spe = is_cmd && (cmd == gbcd_pkg::CMD_SPE);
    assign hit_spd = is_cmd && (cmd == gbcd_pkg::CMD_SPD);
    assign hit_gtl = is_cmd && listen_q && (cmd == gbcd_pkg::CMD_GTL);
    assign hit_sdc = is_cmd && listen_q && (cmd == gbcd_pkg::CMD_SDC);
    assign hit_get = is_cmd && listen_q && (cmd == gbcd_pkg::CMD_GET);

    // Every device accepts under attention; data only once addressed to listen.
    assign acc_active = !ifc && (atn || listen_q);
    assign acc_hold   = !atn && !I_RX_READY;

    assign src_enable = talk_q && !atn && !ifc;
    assign src_valid  = spoll_q ? 1'b1 : (I_TX_VALID && !src_done && !O_TX_ACK);
    assign src_end    = spoll_q ? 1'b0 : I_TX_END;

    always_comb begin
        src_data = I_TX_DATA;
        if (spoll_q) begin
            src_data = I_STATUS;
            src_data[gbcd_pkg::STB_RQS_POS] = srq_q;
        end
    end

    assign stb_sent = src_done && spoll_q;

    gbcd_acceptor u_acceptor (
        .i_clk       (I_CLK_SYS),
        .i_rst_n     (I_NRST),
        .i_active    (acc_active),
        .i_hold      (acc_hold),
        .i_dav_n     (I_DAV_N),
        .i_atn_n     (I_ATN_N),
        .i_eoi_n     (I_EOI_N),
        .i_dio_n     (I_DIO_N),
        .o_nrfd_oe_n (O_NRFD_OE_N),
        .o_ndac_oe_n (O_NDAC_OE_N),
        .o_byte      (acc_byte),
        .o_eoi       (acc_eoi),
        .o_atn       (acc_atn),
        .o_strobe    (acc_strobe)
    );

    gbcd_source u_source (
        .i_clk      (I_CLK_SYS),
        .i_rst_n    (I_NRST),
        .i_enable   (src_enable),
        .i_valid    (src_valid),
        .i_data     (src_data),
        .i_end      (src_end),
        .i_nrfd_n   (I_NRFD_N),
        .i_ndac_n   (I_NDAC_N),
        .o_dio_n    (O_DIO_N),
        .o_dio_oe_n (O_DIO_OE_N),
        .o_dav_oe_n (O_DAV_OE_N),
        .o_eoi_oe_n (O_EOI_OE_N),
        .o_done     (src_done)
    );

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST) begin
            addr_q <= (I_PRI_ADDR > gbcd_pkg::ADDR_MAX) ? gbcd_pkg::ADDR_MAX : I_PRI_ADDR;
        end
    end

    // Open-drain lines only ever pull low, so their driven level is constant.
    always_ff @(posedge I_CLK_SYS) begin
        pin_low_q <= gbcd_pkg::RST_CLR;
    end

    assign O_DAV_N  = pin_low_q;
    assign O_NRFD_N = pin_low_q;
    assign O_NDAC_N = pin_low_q;
    assign O_EOI_N  = pin_low_q;
    assign O_SRQ_N  = pin_low_q;

    // Listener state.
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST) begin
            listen_q <= gbcd_pkg::RST_CLR;
        end else if (ifc) begin
            listen_q <= 1'b0;
        end else if (hit_unl || hit_mta) begin
            listen_q <= 1'b0;
        end else if (hit_mla) begin
            listen_q <= 1'b1;
        end
    end

    // Talker state.
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST) begin
            talk_q <= gbcd_pkg::RST_CLR;
        end else if (ifc) begin
            talk_q <= 1'b0;
        end else if (hit_unt || hit_ota) begin
            talk_q <= 1'b0;
        end else if (hit_mta) begin
            talk_q <= 1'b1;
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST) begin
            spoll_q <= gbcd_pkg::RST_CLR;
        end else if (ifc || hit_spd) begin
            spoll_q <= 1'b0;
        end else if (hit_spe) begin
            spoll_q <= 1'b1;
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST) begin
            srq_q      <= gbcd_pkg::RST_CLR;
            O_SRQ_OE_N <= gbcd_pkg::RST_REL;
        end else begin
            // A new request in the cycle the poll completes is kept.
            if (I_SVC_REQ) begin
                srq_q <= 1'b1;
            end else if (stb_sent) begin
                srq_q <= 1'b0;
            end
            O_SRQ_OE_N <= !(I_SVC_REQ || (srq_q && !stb_sent));
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST) begin
            ren_prev_q <= gbcd_pkg::RST_CLR;
            remote_q   <= gbcd_pkg::RST_CLR;
        end else begin
            ren_prev_q <= ren;
            if (!ren) begin
                remote_q <= 1'b0;
            end else if ((ren && !ren_prev_q) || hit_mla) begin
                remote_q <= 1'b1;
            end else if (hit_gtl) begin
                remote_q <= 1'b0;
            end else if (I_LOCAL_KEY && !lockout_q) begin
                remote_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST) begin
            lockout_q <= gbcd_pkg::RST_CLR;
        end else if (!ren) begin
            lockout_q <= 1'b0;
        end else if (hit_llo) begin
            lockout_q <= 1'b1;
        end else if (hit_gtl && I_GTL_UNLOCKS) begin
            lockout_q <= 1'b0;
        end
    end

    // Mode and lockout flags seen by the instrument.
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST) begin
            O_LISTEN     <= gbcd_pkg::RST_CLR;
            O_TALK       <= gbcd_pkg::RST_CLR;
            O_SPOLL      <= gbcd_pkg::RST_CLR;
            O_REMOTE     <= gbcd_pkg::RST_CLR;
            O_LOCKOUT    <= gbcd_pkg::RST_CLR;
            O_PANEL_LOCK <= gbcd_pkg::RST_CLR;
            O_SRQ_PEND   <= gbcd_pkg::RST_CLR;
        end else begin
            O_LISTEN     <= listen_q;
            O_TALK       <= talk_q;
            O_SPOLL      <= spoll_q;
            O_REMOTE     <= remote_q;
            O_LOCKOUT    <= lockout_q;
            O_PANEL_LOCK <= remote_q && (I_REN_LOCKS_PANEL || lockout_q);
            O_SRQ_PEND   <= srq_q;
        end
    end

    // Device clear and trigger pulses.
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST) begin
            O_DEV_CLEAR <= gbcd_pkg::RST_CLR;
            O_TRIGGER   <= gbcd_pkg::RST_CLR;
        end else begin
            O_DEV_CLEAR <= hit_dcl || hit_sdc;
            O_TRIGGER   <= hit_get;
        end
    end

    // Data bytes for the command parser.
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST) begin
            O_RX_DATA  <= 8'h00;
            O_RX_VALID <= gbcd_pkg::RST_CLR;
            O_RX_END   <= gbcd_pkg::RST_CLR;
        end else begin
            O_RX_VALID <= acc_strobe && !acc_atn;
            if (acc_strobe && !acc_atn) begin
                O_RX_DATA <= acc_byte;
                O_RX_END  <= acc_eoi;
            end
        end
    end

    // Acknowledge of an instrument data byte on the bus.
    always_ff @(posedge I_CLK_SYS) begin
        if (!I_NRST) begin
            O_TX_ACK <= gbcd_pkg::RST_CLR;
        end else begin
            O_TX_ACK <= src_done && !spoll_q;
        end
    end

endmodule : gbcd_top

`default_nettype wire

// ---- tb/gbcd_ctrl_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module gbcd_ctrl_model (
    input  wire logic       i_clk,
    input  wire logic       i_nrfd_n,
    input  wire logic       i_ndac_n,
    input  wire logic       i_dav_n,
    input  wire logic       i_eoi_n,
    input  wire logic [7:0] i_dio_n,
    output var  logic       o_atn_n,
    output var  logic       o_dav_n,
    output var  logic       o_eoi_n,
    output var  logic [7:0] o_dio_n,
    output var  logic       o_nrfd_n,
    output var  logic       o_ndac_n,
    output var  logic       o_hang
);
    initial begin
        {o_atn_n, o_dav_n, o_eoi_n, o_nrfd_n, o_ndac_n, o_hang} = 6'h3E;
        o_dio_n = 8'hFF;
    end

    function automatic logic ok(input int k);
        case (k)
            0: return i_nrfd_n && !i_ndac_n;
            1: return i_ndac_n;
            2: return !i_ndac_n;
            3: return !i_dav_n;
            default: return i_dav_n;
        endcase
    endfunction : ok

    // A stuck handshake sets the hang flag.
    task automatic await(input int k);
        int n;
        n = 0;
        @(posedge i_clk);
        while (!ok(k) && n < 400) begin
            @(posedge i_clk);
            n++;
        end
        if (n >= 400) o_hang <= 1'b1;
    endtask : await

    task automatic send(input logic [7:0] b, input logic atn, input logic eoi);
        o_atn_n <= ~atn;
        o_dio_n <= ~b;
        o_eoi_n <= ~eoi;
        o_nrfd_n <= 1'b1;
        o_ndac_n <= 1'b1;
        @(posedge i_clk);
        await(0);
        o_dav_n <= 1'b0;
        await(1);
        o_dav_n <= 1'b1;
        o_eoi_n <= 1'b1;
        o_dio_n <= 8'hFF;
        await(2);
    endtask : send

    task automatic recv(output logic [7:0] b, output logic e);
        o_atn_n <= 1'b1;
        o_nrfd_n <= 1'b1;
        o_ndac_n <= 1'b0;
        await(3);
        b = ~i_dio_n;
        e = ~i_eoi_n;
        o_nrfd_n <= 1'b0;
        o_ndac_n <= 1'b1;
        await(4);
        o_ndac_n <= 1'b0;
    endtask : recv
endmodule : gbcd_ctrl_model
`default_nettype wire

// ---- tb/gbcd_top_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
module gbcd_top_chk (
    input wire logic I_CLK_SYS,
    input wire logic I_NRST,
    input wire logic I_IFC_N,
    input wire logic I_REN_N,
    input wire logic I_SVC_REQ,
    input wire logic I_ATN_N,
    input wire logic I_EOI_N,
    input wire logic I_DAV_N,
    input wire logic I_NRFD_N,
    input wire logic I_NDAC_N,
    input wire logic O_NRFD_OE_N,
    input wire logic O_DAV_OE_N,
    input wire logic O_SRQ_OE_N,
    input wire logic O_RX_VALID,
    input wire logic O_RX_END,
    input wire logic O_LISTEN,
    input wire logic O_TALK,
    input wire logic O_REMOTE
);
    default clocking cb @(posedge I_CLK_SYS);
    endclocking
    default disable iff (!I_NRST);

    property p_ifc_idle;
        !I_IFC_N |-> ##[1:3] (!O_LISTEN && !O_TALK);
    endproperty
    a_ifc_idle: assert property (p_ifc_idle)
        else $error("ifc kept address");
    property p_srq;
        I_SVC_REQ |-> ##[1:3] !O_SRQ_OE_N;
    endproperty
    a_srq: assert property (p_srq)
        else $error("srq not driven");
    property p_nrfd_hold;
        !O_NRFD_OE_N && !I_DAV_N && I_IFC_N |=> !O_NRFD_OE_N;
    endproperty
    a_nrfd_hold: assert property (p_nrfd_hold)
        else $error("nrfd released early");
    property p_dav_ready;
        $fell(O_DAV_OE_N) |-> $past(I_NRFD_N) && !$past(I_NDAC_N);
    endproperty
    a_dav_ready: assert property (p_dav_ready)
        else $error("dav before ready");
    property p_rx_end;
        O_RX_VALID |-> O_RX_END == !$past(I_EOI_N, 2);
    endproperty
    a_rx_end: assert property (p_rx_end)
        else $error("rx end wrong");
    property p_rx_data;
        O_RX_VALID |-> $past(I_ATN_N, 2) && O_LISTEN;
    endproperty
    a_rx_data: assert property (p_rx_data)
        else $error("bad rx byte");
    property p_ren_on;
        $fell(I_REN_N) |-> ##[1:3] O_REMOTE;
    endproperty
    a_ren_on: assert property (p_ren_on)
        else $error("no remote");
    property p_ren_off;
        $rose(I_REN_N) |-> ##[1:3] !O_REMOTE;
    endproperty
    a_ren_off: assert property (p_ren_off)
        else $error("remote kept");

    c_rx_end: cover property (O_RX_VALID && O_RX_END);
    c_dav: cover property ($fell(O_DAV_OE_N));
    c_remote: cover property (O_REMOTE && !I_REN_N);
endmodule : gbcd_top_chk

bind gbcd_top gbcd_top_chk u_gbcd_top_chk (.*);
`default_nettype wire

// ---- tb/test_gpib_bus_command_decoder.sv ----
`timescale 1ns/1ns
`default_nettype none
module test_gpib_bus_command_decoder;
    localparam int LIMIT = 20000;
    logic       clk = 1'b0;
    logic       nrst = 1'b0;
    logic       ren_n = 1'b1;
    logic       ifc_n = 1'b1;
    logic       key = 1'b0;
    logic       svc = 1'b0;
    logic       tx_vld = 1'b0;
    logic       tx_end = 1'b0;
    logic [7:0] tx_dat = 8'h00;
    logic [7:0] c_dio, d_dio, b_dio, rx_dat, got;
    logic       c_atn, c_dav, c_eoi, c_nrfd, c_ndac, hang, eoi;
    logic       d_dio_oe, d_dav, d_dav_oe, d_nrfd, d_nrfd_oe, d_ndac, d_ndac_oe;
    logic       d_eoi, d_eoi_oe, d_srq_oe, rx_vld, rx_end, tx_ack;
    logic       lsn, tlk, spl, rem, lck, pnl, srqp, dclr, trg;
    logic       b_dav, b_nrfd, b_ndac, b_eoi;
    int         fails = 0, cmp_count = 0, cyc = 0, n_rx = 0, n_clr = 0, n_trg = 0;

    always #4 clk = ~clk;
    assign b_dio = c_dio & (d_dio_oe ? 8'hFF : d_dio);
    assign b_dav = c_dav & (d_dav_oe | d_dav);
    assign b_nrfd = c_nrfd & (d_nrfd_oe | d_nrfd);
    assign b_ndac = c_ndac & (d_ndac_oe | d_ndac);
    assign b_eoi = c_eoi & (d_eoi_oe | d_eoi);

    gbcd_top u_gbcd_top (
        .I_CLK_SYS(clk), .I_NRST(nrst), .I_PRI_ADDR(5'h1F), .I_REN_LOCKS_PANEL(1'b0),
        .I_GTL_UNLOCKS(1'b1), .I_ATN_N(c_atn), .I_IFC_N(ifc_n), .I_REN_N(ren_n),
        .I_EOI_N(b_eoi), .I_DAV_N(b_dav), .I_NRFD_N(b_nrfd), .I_NDAC_N(b_ndac),
        .I_DIO_N(b_dio), .I_LOCAL_KEY(key), .I_SVC_REQ(svc), .I_STATUS(8'h05),
        .I_TX_VALID(tx_vld), .I_TX_DATA(tx_dat), .I_TX_END(tx_end), .I_RX_READY(1'b1),
        .O_DIO_N(d_dio), .O_DIO_OE_N(d_dio_oe), .O_DAV_N(d_dav), .O_DAV_OE_N(d_dav_oe),
        .O_NRFD_N(d_nrfd), .O_NRFD_OE_N(d_nrfd_oe), .O_NDAC_N(d_ndac),
        .O_NDAC_OE_N(d_ndac_oe), .O_EOI_N(d_eoi), .O_EOI_OE_N(d_eoi_oe), .O_SRQ_N(),
        .O_SRQ_OE_N(d_srq_oe), .O_RX_DATA(rx_dat), .O_RX_VALID(rx_vld), .O_RX_END(rx_end),
        .O_TX_ACK(tx_ack), .O_LISTEN(lsn), .O_TALK(tlk), .O_SPOLL(spl), .O_REMOTE(rem),
        .O_LOCKOUT(lck), .O_PANEL_LOCK(pnl), .O_DEV_CLEAR(dclr), .O_TRIGGER(trg),
        .O_SRQ_PEND(srqp)
    );

    gbcd_ctrl_model u_gbcd_ctrl_model (
        .i_clk(clk), .i_nrfd_n(b_nrfd), .i_ndac_n(b_ndac), .i_dav_n(b_dav),
        .i_eoi_n(b_eoi), .i_dio_n(b_dio), .o_atn_n(c_atn), .o_dav_n(c_dav),
        .o_eoi_n(c_eoi), .o_dio_n(c_dio), .o_nrfd_n(c_nrfd), .o_ndac_n(c_ndac),
        .o_hang(hang)
    );

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish

    // Talker request drops once acknowledged.
    always @(posedge clk) begin
        cyc++;
        n_rx += int'(rx_vld === 1'b1);
        n_clr += int'(dclr === 1'b1);
        n_trg += int'(trg === 1'b1);
        if (tx_ack === 1'b1) tx_vld <= 1'b0;
        if (cyc == LIMIT) begin
            fails++;
            tally_and_finish();
        end
    end

    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] seen);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : cmp

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic cmd(input logic [7:0] b);
        u_gbcd_ctrl_model.send(b, 1'b1, 1'b0);
    endtask : cmd

    task automatic t_reset;
        tick(10);
        nrst <= 1'b1;
        tick(2);
        cmp("idle flags", 8'h03, {lsn, tlk, spl, rem, lck, srqp, d_nrfd_oe, d_srq_oe});
        $display("test reset done");
    endtask : t_reset

    task automatic t_addr;
        cmd(8'h08);
        cmd(8'h04);
        cmp("unaddr", 8'h00, 8'(n_clr + n_trg));
        cmd(8'h3E);
        cmp("listen", 8'h01, {7'h00, lsn});
        cmd(8'h7E);
        cmp("scg", 8'h01, {7'h00, lsn});
        cmd(8'h04);
        cmd(8'h08);
        cmp("sdc", 8'h01, 8'(n_clr));
        cmp("triggers", 8'h01, 8'(n_trg));
        cmd(8'h3F);
        cmp("unl", 8'h00, {7'h00, lsn});
        cmd(8'h14);
        cmp("dcl", 8'h02, 8'(n_clr));
        cmd(8'h04);
        cmp("sdc idle", 8'h02, 8'(n_clr));
        $display("test addressing done");
    endtask : t_addr

    task automatic t_data;
        cmd(8'h3E);
        cmp("rx under attention", 8'h00, 8'(n_rx));
        u_gbcd_ctrl_model.send(8'h2A, 1'b0, 1'b0);
        cmp("rx first", 8'h2A, rx_dat);
        cmp("rx first end", 8'h00, {7'h00, rx_end});
        u_gbcd_ctrl_model.send(8'h52, 1'b0, 1'b1);
        cmp("rx last", 8'h52, rx_dat);
        cmp("rx last end", 8'h01, {7'h00, rx_end});
        cmp("rx count", 8'h02, 8'(n_rx));
        cmd(8'h3F);
        $display("test data done");
    endtask : t_data

    task automatic t_remote;
        ren_n <= 1'b0;
        tick(3);
        cmp("remote on", 8'h01, {7'h00, rem});
        cmd(8'h11);
        key <= 1'b1;
        tick(3);
        key <= 1'b0;
        cmp("locked", 8'h07, {5'h00, rem, lck, pnl});
        cmd(8'h3E);
        cmd(8'h01);
        cmp("gtl", 8'h00, {5'h00, rem, lck, pnl});
        cmd(8'h3F);
        ren_n <= 1'b1;
        tick(3);
        cmp("remote off", 8'h00, {7'h00, rem});
        $display("test remote done");
    endtask : t_remote

    task automatic t_poll;
        svc <= 1'b1;
        tick(1);
        svc <= 1'b0;
        tick(3);
        cmp("srq driven", 8'h00, {7'h00, d_srq_oe});
        cmd(8'h18);
        cmd(8'h5E);
        cmp("poll talker", 8'h03, {6'h00, spl, tlk});
        u_gbcd_ctrl_model.recv(got, eoi);
        cmp("status byte", 8'h45, got);
        cmp("status end", 8'h00, {7'h00, eoi});
        tick(3);
        cmp("srq released", 8'h01, {7'h00, d_srq_oe});
        cmd(8'h19);
        cmp("poll off", 8'h00, {7'h00, spl});
        tx_dat <= 8'hA7;
        tx_end <= 1'b1;
        tx_vld <= 1'b1;
        u_gbcd_ctrl_model.recv(got, eoi);
        tick(4);
        cmp("talk byte", 8'hA7, got);
        cmp("talk end", 8'h01, {7'h00, eoi});
        cmp("talk acked", 8'h00, {7'h00, tx_vld});
        cmd(8'h5F);
        cmp("untalk", 8'h00, {7'h00, tlk});
        $display("test poll done");
    endtask : t_poll

    task automatic t_ifc;
        cmd(8'h18);
        cmd(8'h5E);
        cmd(8'h3E);
        cmp("listen again", 8'h01, {7'h00, lsn});
        ifc_n <= 1'b0;
        tick(4);
        ifc_n <= 1'b1;
        tick(3);
        cmp("after clear", 8'h00, {5'h00, lsn, tlk, spl});
        $display("test clear done");
    endtask : t_ifc

    initial begin
        t_reset();
        t_addr();
        t_data();
        t_remote();
        t_poll();
        t_ifc();
        cmp("hang", 8'h00, {7'h00, hang});
        tally_and_finish();
    end
endmodule : test_gpib_bus_command_decoder
`default_nettype wire
